// [brk_pkg.sv]
// Package: register map, field positions and carriers for the address breakpoint unit
package brk_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_ADDR_HIGH    = 8'h04;
	localparam logic [7:0] ADDR_ADDR_LOW     = 8'h08;
	localparam logic [7:0] ADDR_STOPWAIT     = 8'h0c;
	localparam logic [7:0] ADDR_FLAG_CLEAR   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK     = 8'h18;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BIT_BREAK_ENABLE  = 7;
	localparam int BIT_BREAK_ACTIVE  = 6;
	localparam int BIT_STOP_WAIT     = 1;
	localparam int BIT_FLAG_CLEAR_EN = 0;
	localparam int IRQ_BIT_MATCH     = 0;
	localparam int IRQ_BIT_SOFT      = 1;
	localparam int IRQ_BIT_WAKE      = 2;
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HRESP_OKAY    = 2'h0;
	localparam int          IRQ_WIDTH     = 3;

	// Break vector and opcode handed to the core's sequencer
	localparam logic [15:0] VECTOR_NORMAL  = 16'hfffc;
	localparam logic [15:0] VECTOR_MONITOR = 16'hfefc;
	localparam logic [7:0]  SOFTWARE_INTERRUPT_OPCODE = 8'h83;

	// CPU bus view seen by the comparator
	typedef struct packed {
		logic [15:0] addr;
		logic        from_pc;
		logic        last_cycle;
		logic        valid;
	} cpu_bus_t;

	// Side effects while a break is in progress
	typedef struct packed {
		logic timers_halt;
		logic watchdog_off;
		logic flag_clear_allowed;
	} break_effects_t;

	typedef enum logic [1:0] {
		BRK_IDLE,
		BRK_REQUEST,
		BRK_ACTIVE
	} brk_state_t;

endpackage

// [brk_addr_cmp.sv]
// Address comparator for the breakpoint unit
`timescale 1ns/100ps
module brk_addr_cmp #(
	parameter int ADDR_WIDTH = 16
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Compare inputs
	input  wire logic [ADDR_WIDTH-1:0] bus_addr,
	input  wire logic                  qualify,
	input  wire logic [ADDR_WIDTH-1:0] break_addr,
	// Registered hit
	output logic                       hit
);

	// Registered so the hit aligns with the last-cycle marker flop in the main file
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit <= 1'b0;
		end else begin
			hit <= qualify && (bus_addr == break_addr);
		end
	end

endmodule

// [brk_unit.sv]
// Address breakpoint unit with AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// [R01] Enabled address match requests a CPU break
// [R02] Only program-counter fetch addresses may match
// [R03] Core loads interrupt opcode, fetches break vector
// [R04] Match on final cycle starts break immediately
// [R05] Writing one to active flag forces break
// [R06] Return-from-interrupt ends the break state
// [R07] Timers held stopped during break
// [R08] Watchdog off in break with test voltage
// [R09] Enable bit seven gates matches, reset clears
// [R10] Active flag set on match, write-zero clears
// [R11] Software clears active flag before leaving routine
// [R12] Two byte registers hold compare address
// [R13] Break waking stop/wait sets its flag
// [R14] Break interrupt forces exit from stop
// [R15] Unit keeps working during wait mode
// [R16] Flag clearing in break needs enable bit
// [R17] Routine may rewind return address by one
// [R18] Request registered, held until core acknowledges
module brk_unit
	import brk_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [7:0]           haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic [1:0]                hresp,
	// CPU core side
	input  brk_pkg::cpu_bus_t         cpu_bus,
	input  wire logic                 monitor_mode,
	input  wire logic                 break_ack,
	input  wire logic                 rti_executed,
	input  wire logic                 in_stop,
	input  wire logic                 in_wait,
	input  wire logic                 test_high_voltage,
	output logic                      break_request,
	output logic                      break_now,
	output logic [7:0]                break_opcode,
	output logic [15:0]               break_vector,
	output logic                      stop_exit,
	output brk_pkg::break_effects_t   effects,
	output logic                      irq
);
	import brk_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	logic                 break_enable_bit;
	logic                 break_active_flag;
	logic                 stop_wait_break_flag;
	logic                 flag_clear_in_break_enable;
	logic [7:0]           addr_high;
	logic [7:0]           addr_low;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	brk_state_t           state;
	logic                 match_hit;
	logic                 soft_trigger;
	logic                 in_break;
	logic                 hit_last;

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic       dp_valid;
	logic       dp_write;
	logic [7:0] dp_addr;
	logic       wr_ctrl;
	logic       wr_high;
	logic       wr_low;
	logic       wr_sw;
	logic       wr_fc;
	logic       wr_mask;
	logic       rd_irq;
	logic [7:0] wbyte;

	// Only NONSEQ singles are used by the master; the slave never waits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= RESET_BYTE;
		end else if (hready) begin
			dp_valid <= hsel && (htrans == HTRANS_NONSEQ);
			dp_write <= hwrite;
			dp_addr  <= haddr;
		end
	end

	// Write and read strobes in the data phase
	function automatic logic wr_hit(input logic [7:0] a);
		return dp_valid && dp_write && (dp_addr == a);
	endfunction

	assign wbyte   = hwdata[7:0];
	assign wr_ctrl = wr_hit(ADDR_CTRL_STATUS);
	assign wr_high = wr_hit(ADDR_ADDR_HIGH);
	assign wr_low  = wr_hit(ADDR_ADDR_LOW);
	assign wr_sw   = wr_hit(ADDR_STOPWAIT);
	assign wr_fc   = wr_hit(ADDR_FLAG_CLEAR);
	assign wr_mask = wr_hit(ADDR_IRQ_MASK);
	assign rd_irq  = dp_valid && !dp_write && (dp_addr == ADDR_IRQ_STATUS);

	// Slave is always ready with an OKAY answer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// Read data registered in the address phase, valid in the data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= READ_ZERO;
		end else if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
			hrdata <= READ_ZERO;
			unique case (haddr)
				ADDR_CTRL_STATUS: begin
					hrdata[BIT_BREAK_ENABLE] <= break_enable_bit;
					hrdata[BIT_BREAK_ACTIVE] <= break_active_flag;
				end
				ADDR_ADDR_HIGH:  hrdata[7:0] <= addr_high;
				ADDR_ADDR_LOW:   hrdata[7:0] <= addr_low;
				ADDR_STOPWAIT:   hrdata[BIT_STOP_WAIT] <= stop_wait_break_flag;
				ADDR_FLAG_CLEAR: hrdata[BIT_FLAG_CLEAR_EN] <= flag_clear_in_break_enable;
				ADDR_IRQ_STATUS: hrdata[IRQ_WIDTH-1:0] <= irq_status;
				ADDR_IRQ_MASK:   hrdata[IRQ_WIDTH-1:0] <= irq_mask;
				default:         hrdata <= READ_ZERO; // Unmapped reads as zero
			endcase
		end
	end

	// ****************************************
	// Break configuration registers
	// ****************************************

	// Enable bit: software only, cleared by reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_enable_bit <= 1'b0; // R09
		end else if (wr_ctrl) begin
			break_enable_bit <= wbyte[BIT_BREAK_ENABLE]; // R09
		end
	end

	// Compare address bytes, cleared by reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_high <= RESET_BYTE; // R12
			addr_low  <= RESET_BYTE; // R12
		end else begin
			if (wr_high) begin
				addr_high <= wbyte; // R12
			end
			if (wr_low) begin
				addr_low <= wbyte; // R12
			end
		end
	end

	// Flag clear enable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_clear_in_break_enable <= 1'b0;
		end else if (wr_fc) begin
			flag_clear_in_break_enable <= wbyte[BIT_FLAG_CLEAR_EN];
		end
	end

	// ****************************************
	// Address match
	// ****************************************

	// Wait mode does not gate the comparator, so it stays live there
	brk_addr_cmp #(
		.ADDR_WIDTH (16)
	) u_cmp (
		.clk        (clk),
		.reset_n    (reset_n),
		.bus_addr   (cpu_bus.addr),
		.qualify    (cpu_bus.valid && cpu_bus.from_pc && break_enable_bit), // R01 R02 R09 R15
		.break_addr ({addr_high, addr_low}),
		.hit        (match_hit)
	);

	assign soft_trigger = wr_ctrl && wbyte[BIT_BREAK_ACTIVE] && !break_active_flag; // R05

	// Active flag: hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_active_flag <= 1'b0; // R10
		end else if (match_hit || soft_trigger) begin
			break_active_flag <= 1'b1; // R10 R05
		end else if (wr_ctrl && !wbyte[BIT_BREAK_ACTIVE]) begin
			break_active_flag <= 1'b0; // R10 R11
		end
	end

	// ****************************************
	// Break sequencing toward the core
	// ****************************************

	// Request stays up until acknowledged, so none is lost or doubled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= BRK_IDLE;
		end else begin
			unique case (state)
				BRK_IDLE: begin
					if (match_hit || soft_trigger) begin
						state <= BRK_REQUEST; // R18 R01 R05
					end
				end
				BRK_REQUEST: begin
					if (break_ack) begin
						state <= BRK_ACTIVE; // R18
					end
				end
				BRK_ACTIVE: begin
					if (rti_executed) begin
						state <= BRK_IDLE; // R06
					end
				end
			endcase
		end
	end

	assign in_break = (state == BRK_ACTIVE);

	// Last-cycle marker sampled with the address, so it lines up with the hit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_last <= 1'b0;
		end else begin
			hit_last <= cpu_bus.last_cycle; // R04
		end
	end

	// Request outputs; the core finishes its instruction before acting
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_request <= 1'b0;
			break_now     <= 1'b0;
		end else begin
			break_request <= ((state == BRK_IDLE) && (match_hit || soft_trigger))
				|| ((state == BRK_REQUEST) && !break_ack); // R18 R01
			// Match on an instruction's last cycle starts at once
			break_now <= (state == BRK_IDLE) && match_hit && hit_last; // R04
		end
	end

	// Opcode and vector for the core's interrupt sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_opcode <= SOFTWARE_INTERRUPT_OPCODE;
			break_vector <= VECTOR_NORMAL;
		end else begin
			break_opcode <= SOFTWARE_INTERRUPT_OPCODE; // R03
			break_vector <= monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL; // R03
		end
	end

	// ****************************************
	// Low-power interaction
	// ****************************************

	// Stop exit pulse when a break is raised from stop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_exit <= 1'b0;
		end else begin
			stop_exit <= in_stop && (match_hit || soft_trigger); // R14
		end
	end

	// Wake flag: the set wins over a write of zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_wait_break_flag <= 1'b0; // R13
		end else if ((in_stop || in_wait) && (match_hit || soft_trigger)) begin
			stop_wait_break_flag <= 1'b1; // R13
		end else if (wr_sw && !wbyte[BIT_STOP_WAIT]) begin
			stop_wait_break_flag <= 1'b0; // R13 R17
		end
	end

	// ****************************************
	// Side effects during the break
	// ****************************************

	// Registered so downstream blocks see a clean level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			effects <= '0;
		end else begin
			effects.timers_halt        <= in_break; // R07
			effects.watchdog_off       <= in_break && test_high_voltage; // R08
			effects.flag_clear_allowed <= !in_break || flag_clear_in_break_enable; // R16
		end
	end

	// ****************************************
	// Interrupt status and mask
	// ****************************************

	// Sticky events; a read clears them but a same-cycle event survives
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= '0;
		end else begin
			for (int i = 0; i < IRQ_WIDTH; i++) begin
				if ((i == IRQ_BIT_MATCH && match_hit) ||
					(i == IRQ_BIT_SOFT && soft_trigger) ||
					(i == IRQ_BIT_WAKE && (in_stop || in_wait) && (match_hit || soft_trigger))) begin
					irq_status[i] <= 1'b1;
				end else if (rd_irq) begin
					irq_status[i] <= 1'b0;
				end
			end
		end
	end

	// Mask register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= hwdata[IRQ_WIDTH-1:0];
		end
	end

	// Level interrupt from a flop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

// [brk_unit_props.sv]
// Checker: port-level properties of the address breakpoint unit
`timescale 1ns/100ps
module brk_unit_props
	import brk_pkg::*;
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             reset_n,
	// Watched ports
	input wire logic             monitor_mode,
	input wire logic             break_ack,
	input wire logic             test_high_voltage,
	input wire logic             break_request,
	input wire logic             break_now,
	input wire logic [7:0]       break_opcode,
	input wire logic [15:0]      break_vector,
	input wire logic             stop_exit,
	input brk_pkg::break_effects_t effects
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ****************
	// Break link
	// ****************
	a_req_held: assert property (break_request && !break_ack |=> break_request)
		else $error("request dropped before ack");
	a_req_drops: assert property (break_request && break_ack |=> !break_request)
		else $error("request outlived ack");
	a_halt_after_ack: assert property (break_request && break_ack |=> ##1 effects.timers_halt)
		else $error("timers not halted in break");
	a_now_pulse: assert property (break_now |=> !break_now)
		else $error("break_now longer than one cycle");
	a_now_with_req: assert property (break_now |-> break_request)
		else $error("break_now without request");
	a_exit_pulse: assert property (stop_exit |=> !stop_exit)
		else $error("stop_exit longer than one cycle");
	// Watchdog may only be suppressed while the test voltage was present
	a_wdog_needs_tv: assert property (!test_high_voltage |=> !effects.watchdog_off)
		else $error("watchdog off without test voltage");
	a_opcode_fixed: assert property (break_opcode == SOFTWARE_INTERRUPT_OPCODE)
		else $error("wrong break opcode");
	// Vector follows monitor mode one cycle late; first cycle after reset skipped
	a_vector_sel: assert property ($past(reset_n) |->
		break_vector == ($past(monitor_mode) ? VECTOR_MONITOR : VECTOR_NORMAL))
		else $error("wrong break vector");
endmodule

bind brk_unit brk_unit_props brk_unit_props_inst (.clk, .reset_n, .monitor_mode, .break_ack,
	.test_high_voltage, .break_request, .break_now, .break_opcode, .break_vector, .stop_exit, .effects);

// [brk_cpu_model.sv]
// Partner model: CPU core bus and break sequencing
`timescale 1ns/100ps
module brk_cpu_model
	import brk_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Break handshake
	input  wire logic         break_request,
	input  wire logic [3:0]   ack_wait,
	output brk_pkg::cpu_bus_t cpu_bus,
	output logic              break_ack,
	output logic              rti_executed
);
	logic [3:0] cnt;

	// Idle bus carries no valid fetch
	initial begin
		cpu_bus = '{addr: 16'h5a5a, from_pc: 1'b0, last_cycle: 1'b0, valid: 1'b0};
		rti_executed = 1'b0;
	end

	// Ack after ack_wait cycles so both prompt and slow cores are seen
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_ack <= 1'b0;
			cnt <= 4'h0;
		end else if (break_ack) begin
			break_ack <= 1'b0;
		end else if (break_request === 1'b1) begin
			if (cnt == ack_wait) begin
				break_ack <= 1'b1;
				cnt <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end

	// One fetch cycle; afterwards address and qualifiers are inverted so none lingers
	task automatic fetch(input logic [15:0] a, input logic pc, input logic last);
		@(posedge clk);
		cpu_bus <= '{addr: a, from_pc: pc, last_cycle: last, valid: 1'b1};
		@(posedge clk);
		cpu_bus <= '{addr: ~a, from_pc: ~pc, last_cycle: ~last, valid: 1'b0};
	endtask

	// Return-from-interrupt retires
	task automatic retire();
		rti_executed <= 1'b1;
		@(posedge clk);
		rti_executed <= 1'b0;
	endtask
endmodule

// [brk_unit_tb.sv]
// Testbench for the address breakpoint unit
`timescale 1ns/100ps
module brk_unit_tb;
	import brk_pkg::*;
	logic clk, reset_n, hsel, hwrite, hreadyout, rd_dp, now_seen, exit_seen;
	logic [7:0] haddr;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [31:0] expq[$];
	cpu_bus_t cpu_bus;
	break_effects_t effects;
	logic monitor_mode, break_ack, rti_executed, in_stop, in_wait, test_high_voltage;
	logic break_request, break_now, stop_exit, irq;
	logic [7:0] break_opcode;
	logic [15:0] break_vector, ba;
	logic [3:0] ack_wait;
	int err_total, n_tests, cyc;

	brk_unit brk_unit_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_bus, .monitor_mode, .break_ack,
		.rti_executed, .in_stop, .in_wait, .test_high_voltage, .break_request, .break_now,
		.break_opcode, .break_vector, .stop_exit, .effects, .irq);
	brk_cpu_model brk_cpu_model_inst (.clk, .reset_n, .break_request, .ack_wait, .cpu_bus,
		.break_ack, .rti_executed);

	// ****************
	// Clock, checks, verdict
	// ****************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic print_verdict();
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Read data is compared at the edge that closes its data phase
	always @(posedge clk) begin
		if (rd_dp && hreadyout === 1'b1) begin
			chk(hrdata, expq.pop_front());
			chk(32'(hresp), 32'(HRESP_OKAY));
		end
		if (hreadyout === 1'b1) begin
			rd_dp <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
		end
		if (stop_exit === 1'b1) begin
			exit_seen <= 1'b1;
		end
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			print_verdict();
		end
	end

	// ****************
	// Bus and break tasks
	// ****************
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		xfer(a, 1'b0, 32'h0);
	endtask

	// Bounded wait for the request, noting whether break_now pulsed
	task automatic wait_req(input logic now_exp);
		int i;
		now_seen = 1'b0;
		i = 0;
		while (break_request !== 1'b1 && i < 8) begin
			@(posedge clk);
			if (break_now === 1'b1) begin
				now_seen = 1'b1;
			end
			i++;
		end
		chk(32'(break_request), 32'h1);
		chk(32'(now_seen), 32'(now_exp));
	endtask

	// ****************
	// Scenarios
	// ****************
	initial begin
		void'($urandom(124));
		ba = 16'($urandom);
		{hsel, hwrite, rd_dp, now_seen, exit_seen, monitor_mode} = 6'h0;
		{in_stop, in_wait, test_high_voltage} = 3'h0;
		{haddr, htrans, hwdata, ack_wait} = '0;
		hsize = 3'h2;
		{err_total, n_tests, cyc} = '0;
		reset_n = 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		// Every register and the unmapped word read zero after reset
		for (int a = 0; a < 32; a += 4) begin
			rd(8'(a), READ_ZERO);
		end
		chk(32'(break_vector), 32'(VECTOR_NORMAL));
		wr(ADDR_ADDR_HIGH, 32'(ba[15:8]));
		wr(ADDR_ADDR_LOW, 32'(ba[7:0]));
		rd(ADDR_ADDR_HIGH, 32'(ba[15:8]));
		rd(ADDR_ADDR_LOW, 32'(ba[7:0]));
		wr(ADDR_IRQ_MASK, 32'h7);
		// Disabled, non-PC and off-by-one fetches must leave the flag clear
		brk_cpu_model_inst.fetch(ba, 1'b1, 1'b1);
		wr(ADDR_CTRL_STATUS, 32'h80);
		brk_cpu_model_inst.fetch(ba, 1'b0, 1'b1);
		brk_cpu_model_inst.fetch(ba ^ 16'h0001, 1'b1, 1'b1);
		rd(ADDR_CTRL_STATUS, 32'h80);
		rd(ADDR_IRQ_STATUS, 32'h0);
		// Last-cycle match, prompt core, test voltage present
		test_high_voltage <= 1'b1;
		brk_cpu_model_inst.fetch(ba, 1'b1, 1'b1);
		wait_req(1'b1);
		rd(ADDR_CTRL_STATUS, 32'hc0);
		chk(32'(irq), 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h1);
		chk(32'(effects), 32'h6);
		wr(ADDR_FLAG_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(effects), 32'h7);
		wr(ADDR_FLAG_CLEAR, 32'h0);
		wr(ADDR_CTRL_STATUS, 32'h80);
		test_high_voltage <= 1'b0;
		rd(ADDR_CTRL_STATUS, 32'h80);
		brk_cpu_model_inst.retire();
		repeat (4) @(posedge clk);
		chk(32'(effects), 32'h1);
		// Software-forced break while stopped, monitor vector, slow core
		ack_wait <= 4'h5;
		in_stop <= 1'b1;
		monitor_mode <= 1'b1;
		wr(ADDR_CTRL_STATUS, 32'h40);
		wait_req(1'b0);
		chk(32'(break_vector), 32'(VECTOR_MONITOR));
		in_stop <= 1'b0;
		rd(ADDR_STOPWAIT, 32'h2);
		rd(ADDR_IRQ_STATUS, 32'h6);
		chk(32'(exit_seen), 32'h1);
		wr(ADDR_STOPWAIT, 32'h0);
		rd(ADDR_STOPWAIT, 32'h0);
		wr(ADDR_CTRL_STATUS, 32'h0);
		monitor_mode <= 1'b0;
		brk_cpu_model_inst.retire();
		repeat (4) @(posedge clk);
		// Wait-mode match, events masked, not on a last cycle
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_CTRL_STATUS, 32'h80);
		in_wait <= 1'b1;
		brk_cpu_model_inst.fetch(ba, 1'b1, 1'b0);
		wait_req(1'b0);
		chk(32'(irq), 32'h0);
		in_wait <= 1'b0;
		rd(ADDR_STOPWAIT, 32'h2);
		rd(ADDR_IRQ_STATUS, 32'h5);
		wr(ADDR_CTRL_STATUS, 32'h0);
		brk_cpu_model_inst.retire();
		// A second reset clears the compare address high byte
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(ADDR_ADDR_HIGH, 32'h0);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule
